// ==== logic/sra_port.v ====
// serial register access port: byte frames over sixteen register addresses
`timescale 1ns/1ps
`default_nettype none
`include "sra_consts.vh"
// Behaviour
// RULE1: master byte is address nibble, then control nibble
// RULE2: reply byte is summary nibble, then status nibble
// RULE3: chip select fall starts frame, drives, snapshots
// RULE4: output bit changes on serial clock rise
// RULE5: input bit sampled on serial clock fall
// RULE6: only exactly eight sampling edges make valid frame
// RULE7: chip select rise writes control into register
// RULE8: output released while chip select is high
// RULE9: reset sources restore registers; power-on sets battery fail; here mode control is restored by power-on only
// RULE10: address 0 writes mode; 0,1 read voltage
// RULE11: even addresses 2..8 write; pairs read status
// RULE12: address a timing write; a,b read watchdog
// RULE13: addresses c and d are write-only
// RULE14: address e writes mask; e,f read source
// RULE15: summary nibble sent in every frame
// RULE16: voltage summary is or of voltage status
// RULE17: transceiver summary is or of its status
// RULE18: high-side summary is or of its status
// RULE19: low-side summary is or of its status
// RULE20: write frame returns status of same pair
// RULE21: mode or voltage frame clears battery fail
// RULE22: most significant bit first both directions
// RULE23: invalid frame leaves read side effects undone

// limitation: every serial clock phase must last at least four
// system clocks, since each pin edge is seen three clocks late
// trade-off: the pins are fully synchronised, so the reply lags
// the serial clock rise by about three system clocks
// the master must leave select high for four clocks between frames

module sra_port #(
  parameter SYNC_STAGES = 2 // depth of pin synchronisers
) (
  input wire mclk,
  input wire sys_rst,
  // serial pins
  input wire spi_cs_n,
  input wire spi_sclk,
  input wire spi_mosi,
  output wire spi_miso,
  output wire spi_miso_oe,
  // further reset sources
  input wire ext_reset_pin,
  input wire reset_mode_req,
  // status from the rest of the chip, same clock
  input wire [2:0] voltage_status_in,
  input wire [3:0] wake_input_status,
  input wire [3:0] bus_transceiver_status,
  input wire [3:0] high_side_status,
  input wire [3:0] low_side_status,
  input wire [3:0] watchdog_state,
  input wire [3:0] interrupt_source,
  // control registers towards the rest of the chip
  output reg [3:0] mode_control,
  output reg [3:0] wake_input_enable,
  output reg [3:0] bus_transceiver_control,
  output reg [3:0] high_side_control,
  output reg [3:0] low_side_control,
  output reg [2:0] watchdog_period,
  output reg [2:0] cyclic_sense_timing,
  output reg [3:0] analog_mux_control,
  output reg [3:0] configuration,
  output reg [3:0] interrupt_mask,
  output reg battery_fail_flag,
  // one pulse per accepted frame
  output reg frame_write,
  output reg [3:0] frame_addr
);

  // ============================================================
  // pin synchronisers

  // raw pins gathered so one loop can sync them all
  wire [3:0] pin_raw;
  // stage chains, one row per pin
  reg [SYNC_STAGES-1:0] sync_chain [0:3];
  // last stage of each chain
  wire [3:0] pin_sync;

  assign pin_raw = {ext_reset_pin, spi_mosi, spi_sclk, spi_cs_n};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      // first stage is read only by the next stage
      // two stages trade two clocks of lag for metastability margin
      always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          // chip select idles high, others low
          // so no false frame start follows reset
          sync_chain[gi] <= (gi == 0) ? {SYNC_STAGES{1'b1}} : {SYNC_STAGES{1'b0}};
        end else begin
          sync_chain[gi] <= {sync_chain[gi][SYNC_STAGES-2:0], pin_raw[gi]};
        end
      end
      assign pin_sync[gi] = sync_chain[gi][SYNC_STAGES-1];
    end
  endgenerate

  // named views of the synchronised pins
  // nothing below reads a raw pin or a first stage
  wire cs_n_s;
  wire sclk_s;
  wire mosi_s;
  wire ext_rst_s;
  assign cs_n_s = pin_sync[0];
  assign sclk_s = pin_sync[1];
  assign mosi_s = pin_sync[2];
  assign ext_rst_s = pin_sync[3];

  // ============================================================
  // edge detection on synchronised levels

  reg cs_n_d; // previous chip select
  reg sclk_d; // previous serial clock

  // delayed copies give one-cycle edge pulses
  // reset values match the idle pin levels to avoid a false edge
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_n_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      cs_n_d <= cs_n_s;
      sclk_d <= sclk_s;
    end
  end

  wire cs_fall;
  wire cs_rise;
  wire sclk_rise;
  wire sclk_fall;
  assign cs_fall = cs_n_d & ~cs_n_s;
  assign cs_rise = ~cs_n_d & cs_n_s;
  // serial clock edges count only inside a frame
  assign sclk_rise = ~sclk_d & sclk_s & ~cs_n_s;
  assign sclk_fall = sclk_d & ~sclk_s & ~cs_n_s;

  // soft reset: reset mode or the external reset pin
  // it leaves mode control and the battery flag alone
  wire soft_rst;
  assign soft_rst = ext_rst_s | reset_mode_req;

  // ============================================================
  // reply assembly

  // voltage nibble with the battery flag in the low bit
  wire [3:0] voltage_status;
  assign voltage_status = {voltage_status_in, battery_fail_flag};

  // summary bits: any set bit of the matching status
  // built from live status; the frame engine snapshots them at select fall
  wire voltage_summary;
  wire transceiver_summary;
  wire high_side_summary;
  wire low_side_summary;
  assign voltage_summary = |voltage_status; // see RULE16
  assign transceiver_summary = |bus_transceiver_status; // see RULE17
  assign high_side_summary = |high_side_status; // see RULE18
  assign low_side_summary = |low_side_status; // see RULE19

  // summary nibble, voltage in the top bit
  wire [3:0] system_summary_status;
  assign system_summary_status = {voltage_summary, transceiver_summary,
                                  high_side_summary, low_side_summary}; // see RULE15

  // status nibble chosen by address; even and odd of a pair agree
  // one decoder for every address keeps the pairs consistent
  function [3:0] status_nibble;
    input [3:0] addr;
    input [3:0] vs;
    input [3:0] ws;
    input [3:0] ts;
    input [3:0] hs;
    input [3:0] ls;
    input [3:0] wd;
    input [3:0] is;
    begin
      status_nibble = 4'h0;
      if (addr == `SRA_ADDR_MODE || addr == `SRA_ADDR_VOLT) begin
        status_nibble = vs; // see RULE10
      end else if (addr == `SRA_ADDR_WAKE || addr == `SRA_ADDR_WAKE_ST) begin
        status_nibble = ws; // see RULE11
      end else if (addr == `SRA_ADDR_XCVR || addr == `SRA_ADDR_XCVR_ST) begin
        status_nibble = ts; // see RULE11
      end else if (addr == `SRA_ADDR_HS || addr == `SRA_ADDR_HS_ST) begin
        status_nibble = hs; // see RULE11
      end else if (addr == `SRA_ADDR_LS || addr == `SRA_ADDR_LS_ST) begin
        status_nibble = ls; // see RULE11
      end else if (addr == `SRA_ADDR_TIM || addr == `SRA_ADDR_WD_ST) begin
        status_nibble = wd; // see RULE12
      end else if (addr == `SRA_ADDR_IMASK || addr == `SRA_ADDR_ISRC) begin
        status_nibble = is; // see RULE14
      end else begin
        // write-only pair c,d has nothing to return
        status_nibble = 4'h0; // see RULE13
      end
    end
  endfunction

  // ============================================================
  // frame engine

  reg [7:0] rx_shift; // incoming byte, msb first
  reg [7:0] tx_shift; // outgoing byte, msb in bit 7
  reg [3:0] edge_cnt; // sampling edges seen, saturating
  reg miso_q; // registered output bit
  reg miso_oe_q; // registered output enable

  // the address nibble after four bits selects the reply status;
  // the reply must exist before the address arrives, so the lower
  // nibble is built at the fourth sample from live status
  wire [3:0] addr_now;
  assign addr_now = {rx_shift[2:0], mosi_s};

  // shift, count and drive; all edges come from the sync path
  // a rise before the first fall only sets up the master, so it is ignored
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      edge_cnt <= 4'h0;
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end else if (cs_fall) begin
      // new frame: snapshot summary, drive at once
      edge_cnt <= 4'h0; // see RULE3
      rx_shift <= 8'h00;
      tx_shift <= {system_summary_status, 4'h0}; // see RULE2
      miso_q <= system_summary_status[3]; // see RULE22
      miso_oe_q <= 1'b1; // see RULE3
    end else if (cs_n_s) begin
      // idle: output released
      // driving zero keeps the output free of unknowns when released
      miso_oe_q <= 1'b0; // see RULE8
      miso_q <= 1'b0;
    end else begin
      if (sclk_fall) begin
        // sample master bit
        rx_shift <= {rx_shift[6:0], mosi_s}; // see RULE5
        if (edge_cnt != `SRA_CNT_MAX) begin
          edge_cnt <= edge_cnt + 4'h1;
        end
        if (edge_cnt == 4'h3) begin
          // address complete: load reply status of that address;
          // three shifts have passed, so bit 6 goes out next and
          // the status nibble must sit in bits 6 down to 3
          tx_shift[6:3] <= status_nibble(addr_now, voltage_status,
            wake_input_status, bus_transceiver_status, high_side_status,
            low_side_status, watchdog_state, interrupt_source); // see RULE20
        end
      end else if (sclk_rise && edge_cnt != 4'h0) begin
        // present next reply bit, msb first
        tx_shift <= {tx_shift[6:0], 1'b0}; // see RULE4
        miso_q <= tx_shift[6]; // see RULE22
      end
    end
  end

  assign spi_miso = miso_q;
  assign spi_miso_oe = miso_oe_q;

  // accepted frame: exactly eight samples at chip select rise
  // a cut or stretched frame leaves the count off eight and is dropped
  wire frame_ok;
  assign frame_ok = cs_rise & (edge_cnt == `SRA_FRAME_BITS); // see RULE6

  // address and control halves of the received byte
  // meaningful only once eight samples are in
  wire [3:0] register_address_field;
  wire [3:0] control_nibble;
  assign register_address_field = rx_shift[7:4]; // see RULE1
  assign control_nibble = rx_shift[3:0]; // see RULE1

  // ============================================================
  // control registers

  // mode control restores only on power-on
  // reset mode and the reset pin leave it alone
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_control <= `SRA_RST_MODE; // see RULE9
    end else if (frame_ok && register_address_field == `SRA_ADDR_MODE) begin
      mode_control <= control_nibble; // see RULE10
    end
  end

  // battery flag: set at power-on, cleared by a valid mode or voltage frame
  // only power-on sets it, so no set and clear can meet in one cycle
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      battery_fail_flag <= 1'b1; // see RULE9
    end else if (frame_ok && (register_address_field == `SRA_ADDR_MODE ||
                              register_address_field == `SRA_ADDR_VOLT)) begin
      // reported at the fourth sample already; invalid frames keep it
      battery_fail_flag <= 1'b0; // see RULE21
    end
  end

  // remaining write registers, restored by any reset source
  // soft reset is synchronous: both sources already sit in this domain
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_input_enable <= `SRA_RST_WAKE;
      bus_transceiver_control <= `SRA_RST_XCVR;
      high_side_control <= `SRA_RST_HS;
      low_side_control <= `SRA_RST_LS;
      watchdog_period <= `SRA_RST_WDP;
      cyclic_sense_timing <= `SRA_RST_CYC;
      analog_mux_control <= `SRA_RST_AMUX;
      configuration <= `SRA_RST_CFG;
      interrupt_mask <= `SRA_RST_IMASK;
    end else if (soft_rst) begin
      // reset mode and pin reset win over a frame
      wake_input_enable <= `SRA_RST_WAKE; // see RULE9
      bus_transceiver_control <= `SRA_RST_XCVR; // see RULE9
      high_side_control <= `SRA_RST_HS;
      low_side_control <= `SRA_RST_LS;
      watchdog_period <= `SRA_RST_WDP;
      cyclic_sense_timing <= `SRA_RST_CYC;
      analog_mux_control <= `SRA_RST_AMUX;
      configuration <= `SRA_RST_CFG;
      interrupt_mask <= `SRA_RST_IMASK;
    end else if (frame_ok) begin
      // end of frame moves control into the addressed register
      if (register_address_field == `SRA_ADDR_WAKE) begin
        wake_input_enable <= control_nibble; // see RULE7
      end else if (register_address_field == `SRA_ADDR_XCVR) begin
        bus_transceiver_control <= control_nibble; // see RULE11
      end else if (register_address_field == `SRA_ADDR_HS) begin
        high_side_control <= control_nibble; // see RULE11
      end else if (register_address_field == `SRA_ADDR_LS) begin
        low_side_control <= control_nibble; // see RULE11
      end else if (register_address_field == `SRA_ADDR_TIM) begin
        // top bit picks which timing field the low bits set
        if (control_nibble[`SRA_TIM_SEL_BIT] == `SRA_TIM_SEL_CYCLIC) begin
          cyclic_sense_timing <= control_nibble[2:0]; // see RULE12
        end else begin
          watchdog_period <= control_nibble[2:0]; // see RULE12
        end
      end else if (register_address_field == `SRA_ADDR_AMUX) begin
        analog_mux_control <= control_nibble; // see RULE13
      end else if (register_address_field == `SRA_ADDR_CFG) begin
        configuration <= control_nibble; // see RULE13
      end else if (register_address_field == `SRA_ADDR_IMASK) begin
        interrupt_mask <= control_nibble; // see RULE14
      end
    end
  end

  // ============================================================
  // frame report for neighbours (watchdog clear, read-to-clear)

  // one pulse per valid frame, address held until the next one
  // neighbours act on this pulse, never on the raw pins
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_write <= 1'b0;
      frame_addr <= 4'h0;
    end else begin
      frame_write <= frame_ok; // see RULE23
      if (frame_ok) begin
        frame_addr <= register_address_field;
      end
    end
  end

endmodule // sra_port
`default_nettype wire

// ==== logic/sra_consts.vh ====
// constants for the serial register access port
`ifndef SRA_CONSTS_VH
`define SRA_CONSTS_VH

// ============================================================
// frame layout
`define SRA_FRAME_BITS 4'h8
`define SRA_CNT_MAX 4'hf

// ============================================================
// register addresses, one 4-bit address space
`define SRA_ADDR_MODE 4'h0
`define SRA_ADDR_VOLT 4'h1
`define SRA_ADDR_WAKE 4'h2
`define SRA_ADDR_WAKE_ST 4'h3
`define SRA_ADDR_XCVR 4'h4
`define SRA_ADDR_XCVR_ST 4'h5
`define SRA_ADDR_HS 4'h6
`define SRA_ADDR_HS_ST 4'h7
`define SRA_ADDR_LS 4'h8
`define SRA_ADDR_LS_ST 4'h9
`define SRA_ADDR_TIM 4'ha
`define SRA_ADDR_WD_ST 4'hb
`define SRA_ADDR_AMUX 4'hc
`define SRA_ADDR_CFG 4'hd
`define SRA_ADDR_IMASK 4'he
`define SRA_ADDR_ISRC 4'hf

// ============================================================
// timing control fields
`define SRA_TIM_SEL_BIT 3
`define SRA_TIM_SEL_CYCLIC 1'h1

// ============================================================
// reset values
`define SRA_RST_MODE 4'hc
`define SRA_RST_WAKE 4'hf
`define SRA_RST_XCVR 4'h0
`define SRA_RST_HS 4'h0
`define SRA_RST_LS 4'h0
`define SRA_RST_WDP 3'h0
`define SRA_RST_CYC 3'h0
`define SRA_RST_AMUX 4'h0
`define SRA_RST_CFG 4'h0
`define SRA_RST_IMASK 4'h0

`endif

// ==== test/sra_port_chk_sva.sv ====
// checker for the serial register access port
`timescale 1ns/1ps
`default_nettype none
module sra_port_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic ext_reset_pin,
  input wire logic reset_mode_req,
  input wire logic [3:0] mode_control,
  input wire logic [3:0] high_side_control,
  input wire logic battery_fail_flag,
  input wire logic frame_write,
  input wire logic [3:0] frame_addr
);
  // ====
  // one clock domain, pins seen through synchronisers
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  oe_drive_a: assert property ($fell(spi_cs_n) |-> ##[2:5] spi_miso_oe)
    else $error("output not driven after select fall");
  // bit may only move shortly after a clock high phase
  miso_edge_a: assert property (spi_miso_oe && $past(spi_miso_oe) && $changed(spi_miso) |->
    $past(spi_sclk) || $past(spi_sclk, 2) || $past(spi_sclk, 3) || $past(spi_sclk, 4))
    else $error("output bit moved outside clock rise");
  oe_release_a: assert property (spi_cs_n [*6] |-> !spi_miso_oe)
    else $error("output driven while deselected");
  write_pulse_a: assert property (frame_write |=> !frame_write)
    else $error("frame pulse longer than one cycle");
  write_after_cs_a: assert property (frame_write |-> spi_cs_n && $past(spi_cs_n, 2))
    else $error("frame accepted while selected");
  battery_fail_flag_clear_a: assert property ($fell(battery_fail_flag) |->
    frame_write && frame_addr[3:1] == 3'h0)
    else $error("battery flag cleared without voltage frame");
  mode_write_a: assert property ($changed(mode_control) |-> frame_write && frame_addr == 4'h0)
    else $error("mode changed without frame to it");
  // soft resets may also move the high-side control
  hs_write_a: assert property ($changed(high_side_control) && !$past(reset_mode_req) &&
    !($past(ext_reset_pin, 2) || $past(ext_reset_pin, 3) || $past(ext_reset_pin, 4))
    |-> frame_write && frame_addr == 4'h6)
    else $error("high side changed without frame to it");
  cover property (frame_write && frame_addr == 4'ha);
  cover property ($fell(battery_fail_flag));
  cover property ($rose(spi_miso_oe));
endmodule // sra_port_chk
bind sra_port sra_port_chk chk (.*);
`default_nettype wire

// ==== test/sra_master.sv ====
// serial bus master model driving frames into the port
`timescale 1ns/1ps
`default_nettype none
module sra_master (
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_mosi,
  input wire logic miso_w
);
  // idle: deselected, clock low and still
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end
  // one frame of n clocks, odd phase against the system clock
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    #7 spi_cs_n = 1'b0;
    #160;
    for (int i = 0; i < n; i++) begin
      spi_sclk = 1'b1;
      spi_mosi = (i < 8) ? tx[7 - i] : ~spi_mosi;
      #80 spi_sclk = 1'b0;
      rx = {rx[6:0], miso_w};
      #80;
    end
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi; // no stale bit left on the line
    #200;
  endtask
endmodule // sra_master
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the serial register access port
`timescale 1ns/1ps
`default_nettype none
`include "sra_consts.vh"
module testbench;
  // ====
  // stimulus and observed wires
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic ext_reset_pin = 1'b0;
  logic reset_mode_req = 1'b0;
  logic [2:0] voltage_status_in = 3'h5;
  logic [3:0] wake_input_status = 4'h3, bus_transceiver_status = 4'h5, high_side_status = 4'h0;
  logic [3:0] low_side_status = 4'h8, watchdog_state = 4'h6, interrupt_source = 4'hc;
  logic bf_exp = 1'b1; // battery flag as we expect it
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  wire spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe, battery_fail_flag, frame_write;
  wire [3:0] mode_control, wake_input_enable, bus_transceiver_control, high_side_control;
  wire [3:0] low_side_control, analog_mux_control, configuration, interrupt_mask, frame_addr;
  wire [2:0] watchdog_period, cyclic_sense_timing;
  wire miso_w = spi_miso_oe ? spi_miso : 1'bz; // released line floats
  sra_port dut (.*);
  sra_master m (.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .miso_w(miso_w));
  initial forever #10 mclk = ~mclk;
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic complete_run;
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // expected reply byte, summary snapshot then status pair
  function automatic logic [7:0] reply(input logic [3:0] a);
    logic [3:0] s;
    case (a[3:1])
      3'h0: s = {voltage_status_in, bf_exp};
      3'h1: s = wake_input_status;
      3'h2: s = bus_transceiver_status;
      3'h3: s = high_side_status;
      3'h4: s = low_side_status;
      3'h5: s = watchdog_state;
      3'h6: s = 4'h0;
      default: s = interrupt_source;
    endcase
    reply = {|{voltage_status_in, bf_exp}, |bus_transceiver_status, |high_side_status, |low_side_status, s};
  endfunction
  function automatic logic [3:0] ctl(input logic [3:0] a);
    case (a)
      4'h0: ctl = mode_control;
      4'h2: ctl = wake_input_enable;
      4'h4: ctl = bus_transceiver_control;
      4'h6: ctl = high_side_control;
      4'h8: ctl = low_side_control;
      4'ha: ctl = {1'b1, cyclic_sense_timing};
      4'hc: ctl = analog_mux_control;
      4'hd: ctl = configuration;
      default: ctl = interrupt_mask;
    endcase
  endfunction
  // one frame; reply judged only when the count is legal
  task automatic frame(input logic [3:0] a, input logic [3:0] c, input int n, input logic [7:0] e);
    logic [7:0] r;
    m.xfer({a, c}, n, r);
    if (n == 8) begin
      chk("reply", e, r);
      chk("addr", {4'h0, a}, {4'h0, frame_addr});
      if (a[3:1] == 3'h0) bf_exp = 1'b0;
    end
  endtask
  task automatic setst(input logic [2:0] v, input logic [3:0] x, input logic [3:0] h, input logic [3:0] l);
    @(posedge mclk);
    voltage_status_in <= v;
    bus_transceiver_status <= x;
    high_side_status <= h;
    low_side_status <= l;
    @(posedge mclk);
  endtask
  // ====
  // scenarios
  task automatic t_reset;
    chk("rst0", {`SRA_RST_MODE, `SRA_RST_WAKE}, {mode_control, wake_input_enable});
    chk("rst1", {`SRA_RST_XCVR, `SRA_RST_HS}, {bus_transceiver_control, high_side_control});
    chk("rst2", {`SRA_RST_LS, `SRA_RST_AMUX}, {low_side_control, analog_mux_control});
    chk("rst3", {`SRA_RST_CFG, `SRA_RST_IMASK}, {configuration, interrupt_mask});
    chk("rst4", {1'b0, `SRA_RST_WDP, 1'b0, `SRA_RST_CYC}, {1'b0, watchdog_period, 1'b0, cyclic_sense_timing});
    chk("bf", 8'h01, {7'h0, battery_fail_flag});
  endtask
  // every address once; writes land, pairs read back
  task automatic t_loop;
    for (int i = 0; i < 16; i++) begin
      frame(i[3:0], i[3:0] ^ 4'h5, 8, reply(i[3:0]));
      if (!i[0] || i == 13) chk("ctl", {4'h0, i[3:0] ^ 4'h5}, {4'h0, ctl(i[3:0])});
    end
    chk("bf", 8'h00, {7'h0, battery_fail_flag});
    frame(4'ha, 4'h4, 8, reply(4'ha));
    chk("wdp", 8'h04, {5'h0, watchdog_period});
  endtask
  task automatic t_soft;
    setst(3'h0, 4'h0, 4'h4, 4'h0);
    frame(4'h2, 4'h0, 8, reply(4'h2));
    @(posedge mclk) ext_reset_pin <= 1'b1;
    repeat (6) @(posedge mclk);
    ext_reset_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("ext", {`SRA_RST_WAKE, 4'h5}, {wake_input_enable, mode_control});
    frame(4'h2, 4'h0, 8, reply(4'h2));
    @(posedge mclk) reset_mode_req <= 1'b1;
    @(posedge mclk) reset_mode_req <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("rmode", {4'h0, `SRA_RST_WAKE}, {4'h0, wake_input_enable});
  endtask
  // wrong counts change nothing, not even the battery flag
  task automatic t_invalid;
    frame(4'he, 4'h1, 7, 8'h00);
    frame(4'he, 4'h1, 9, 8'h00);
    chk("imask", {4'h0, `SRA_RST_IMASK}, {4'h0, interrupt_mask});
    @(posedge mclk) sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    bf_exp = 1'b1;
    repeat (4) @(posedge mclk);
    frame(4'h1, 4'h0, 7, 8'h00);
    chk("bf", 8'h01, {7'h0, battery_fail_flag});
    frame(4'h1, 4'h0, 8, reply(4'h1));
    frame(4'h0, 4'h0, 8, reply(4'h0));
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    t_reset();
    t_loop();
    t_soft();
    t_invalid();
    complete_run();
  end
endmodule // testbench
`default_nettype wire
